// ===== common/fcsl_pkg.sv
// package: constants, types and register map of the flash command host controller
package fcsl_pkg;
  // ==========================================================================
  // timing at 250 MHz
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_STROBE_NS = 60;
  localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_PROT_PROG_US = 1;
  localparam int T_PROT_ERASE_US = 100;
  localparam int PROT_ERASE_CYC = T_PROT_ERASE_US * 1000000 / CLK_PERIOD_PS;
  localparam int PROT_PROG_CYC = T_PROT_PROG_US * 1000000 / CLK_PERIOD_PS;
  // ==========================================================================
  // widths
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int SECT_LSB = 15;
  localparam int BUF_MAX_WORDS = 16;
  localparam int MAX_SEQ_CYCLES = 21;
  // ==========================================================================
  // device command codes
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_WBUF = 16'h0025;
  localparam logic [15:0] CMD_WBUF_CONF = 16'h0029;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_BYPASS = 16'h0020;
  localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_SECT_ERASE = 16'h0030;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
  localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002AA;
  localparam logic [21:0] AS_MANUF = 22'h000000;
  localparam logic [21:0] AS_DEV1 = 22'h000001;
  localparam logic [21:0] AS_DEV2 = 22'h00000E;
  localparam logic [21:0] AS_DEV3 = 22'h00000F;
  localparam logic [21:0] AS_SECPROT = 22'h000003;
  localparam logic [21:0] AS_GRPPROT = 22'h000002;
  // status bit positions in read data
  localparam int POLL_BIT = 7;
  localparam int TIMEOUT_BIT = 5;
  // ==========================================================================
  // controller registers (AHB byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_ID = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [31:0] ID_VALUE = 32'h0000A5C3; // arbitrary value
  // ==========================================================================
  // operation codes written into ctrl[3:0]
  typedef enum logic [3:0] {
    FCSL_OP_READ = 4'h0,
    FCSL_OP_RESET = 4'h1,
    FCSL_OP_PROGRAM = 4'h2,
    FCSL_OP_SECT_ERASE = 4'h3,
    FCSL_OP_CHIP_ERASE = 4'h4,
    FCSL_OP_SUSPEND = 4'h5,
    FCSL_OP_RESUME = 4'h6,
    FCSL_OP_AUTOSEL = 4'h7,
    FCSL_OP_BYPASS = 4'h8,
    FCSL_OP_BYP_PROG = 4'h9,
    FCSL_OP_BYP_EXIT = 4'hA,
    FCSL_OP_WBUF = 4'hB,
    FCSL_OP_ABORT_RST = 4'hC
  } fcsl_op_t;
  // one bus cycle on the flash pins
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcsl_cyc_t;
  // flash pin bundle driven by the host
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
  } fcsl_pins_t;
endpackage : fcsl_pkg

// ===== verilog/fcsl_cycle.sv
// one flash bus cycle (write or read) driven from the strobe pins
`timescale 1ns/1ps
module fcsl_cycle
  import fcsl_pkg::*;
#(
  parameter int STROBE = STROBE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire fcsl_cyc_t cyc,
  input wire logic [DATA_W-1:0] dq_in,
  output fcsl_pins_t pins,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic done,
  output logic [DATA_W-1:0] rdata
);
  typedef enum logic [1:0] {
    FCSL_C_IDLE = 2'b00,
    FCSL_C_SETUP = 2'b01,
    FCSL_C_PULSE = 2'b10,
    FCSL_C_HOLD = 2'b11
  } fcsl_cst_t;
  fcsl_cst_t st;
  logic [7:0] cnt;
  logic wr;

  // ==========================================================================
  // strobe sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= FCSL_C_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
      dq_out <= '0;
      dq_oe <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      case (st)
        FCSL_C_IDLE: begin
          if (start) begin
            // address and ce settle before we falls: address latches at later edge
            pins.addr <= cyc.addr;
            pins.ce_n <= 1'b0;
            wr <= cyc.wr;
            dq_out <= cyc.data;
            dq_oe <= cyc.wr;
            cnt <= 8'h00;
            st <= FCSL_C_SETUP;
          end
        end
        FCSL_C_SETUP: begin
          if (wr) begin
            pins.we_n <= 1'b0;
          end else begin
            pins.oe_n <= 1'b0;
          end
          st <= FCSL_C_PULSE;
        end
        FCSL_C_PULSE: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(STROBE)) begin
            // we rises first, data held past it
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!wr) begin
              rdata <= dq_in;
            end
            st <= FCSL_C_HOLD;
          end
        end
        FCSL_C_HOLD: begin
          pins.ce_n <= 1'b1;
          dq_oe <= 1'b0;
          done <= 1'b1;
          st <= FCSL_C_IDLE;
        end
        default: st <= FCSL_C_IDLE;
      endcase
    end
  end

  property p_we_needs_ce;
    @(posedge hclk) disable iff (!hresetn) !pins.we_n |-> !pins.ce_n;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce) else $error("we low without ce");

  property p_data_held;
    @(posedge hclk) disable iff (!hresetn) $rose(pins.we_n) |-> dq_oe && $stable(dq_out);
  endproperty
  a_data_held: assert property (p_data_held) else $error("data not held at we rise");
endmodule : fcsl_cycle

// ===== verilog/fcsl_host.sv
// host controller issuing flash command sequences and polling write status
//
// Contract
// - last buffer location lies in same buffer page as start address; the host does not check this and adds offsets across the page end.
// - buffer sequence length follows word count minus one, at most 21 cycles.
// - all command cycles are writes except reads and autoselect fourth cycle.
// - device identity is read in three cycles; last tells boot location.
// - bypass program only after bypass entry (the host issues it whatever its bypass flag holds); bypass reset leaves bypass.
// - host re-reads to get valid data on all eight bits.
`timescale 1ns/1ps
module fcsl_host
  import fcsl_pkg::*;
#(
  parameter int POLL_LIMIT = 1000000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output fcsl_pins_t pins,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {
    FCSL_IDLE = 3'b000,
    FCSL_ISSUE = 3'b001,
    FCSL_WAIT = 3'b010,
    FCSL_POLL = 3'b011,
    FCSL_RECHK = 3'b100,
    FCSL_RST = 3'b101,
    FCSL_RSTW = 3'b110
  } fcsl_st_t;

  fcsl_st_t st;
  fcsl_op_t op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [3:0] wc;
  logic busy;
  logic fail;
  logic bypass;
  logic suspended;
  logic [4:0] idx;
  logic [4:0] nseq;
  logic [31:0] polls;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] buf_mem [BUF_MAX_WORDS];
  logic cstart;
  fcsl_cyc_t cyc;
  logic cdone;
  logic [DATA_W-1:0] crdata;
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic poll_ok;

  // ==========================================================================
  // sequence decoding
  function automatic logic [4:0] seq_len(input fcsl_op_t o, input logic [3:0] w);
    case (o)
      FCSL_OP_READ, FCSL_OP_RESET, FCSL_OP_SUSPEND, FCSL_OP_RESUME: seq_len = 5'd1;
      FCSL_OP_PROGRAM, FCSL_OP_AUTOSEL: seq_len = 5'd4;
      FCSL_OP_SECT_ERASE, FCSL_OP_CHIP_ERASE: seq_len = 5'd6;
      FCSL_OP_BYPASS, FCSL_OP_ABORT_RST: seq_len = 5'd3;
      FCSL_OP_BYP_PROG, FCSL_OP_BYP_EXIT: seq_len = 5'd2;
      FCSL_OP_WBUF: seq_len = 5'(w) + 5'd6;
      default: seq_len = 5'd1;
    endcase
  endfunction : seq_len

  function automatic fcsl_cyc_t unl(input logic [4:0] i, input logic [15:0] c);
    // unlock addresses carry zero above bit eleven, data zero above bit seven
    case (i)
      5'd0: unl = '{wr: 1'b1, addr: ADDR_UNLOCK1, data: CMD_UNLOCK1};
      5'd1: unl = '{wr: 1'b1, addr: ADDR_UNLOCK2, data: CMD_UNLOCK2};
      default: unl = '{wr: 1'b1, addr: ADDR_UNLOCK1, data: c};
    endcase
  endfunction : unl

  logic [ADDR_W-1:0] sect;
  assign sect = {addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};

  always_comb begin
    cyc = '{wr: 1'b1, addr: addr, data: data};
    case (op)
      FCSL_OP_READ: cyc = '{wr: 1'b0, addr: addr, data: '0};
      FCSL_OP_RESET: cyc.data = CMD_RESET;
      FCSL_OP_SUSPEND: cyc = '{wr: 1'b1, addr: sect, data: CMD_SUSPEND};
      FCSL_OP_RESUME: cyc = '{wr: 1'b1, addr: sect, data: CMD_RESUME};
      FCSL_OP_PROGRAM: cyc = (idx < 5'd3) ? unl(idx, CMD_PROGRAM) : cyc;
      FCSL_OP_AUTOSEL: cyc = (idx < 5'd3) ? unl(idx, CMD_AUTOSEL) :
                             '{wr: 1'b0, addr: addr, data: '0};
      FCSL_OP_BYPASS: cyc = unl(idx, CMD_BYPASS);
      FCSL_OP_ABORT_RST: cyc = unl(idx, CMD_RESET);
      FCSL_OP_BYP_PROG: if (idx == 5'd0) cyc.data = CMD_PROGRAM;
      FCSL_OP_BYP_EXIT: cyc.data = (idx == 5'd0) ? CMD_AUTOSEL : CMD_BYP_EXIT2;
      FCSL_OP_SECT_ERASE, FCSL_OP_CHIP_ERASE: begin
        if (idx == 5'd2) cyc = unl(5'd2, CMD_ERASE_SETUP);
        else if (idx < 5'd5) cyc = unl((idx < 5'd2) ? idx : idx - 5'd3, 16'h0);
        else if (op == FCSL_OP_SECT_ERASE) cyc = '{wr: 1'b1, addr: sect, data: CMD_SECT_ERASE};
        else cyc = unl(5'd2, CMD_CHIP_ERASE);
      end
      FCSL_OP_WBUF: begin
        if (idx < 5'd2) cyc = unl(idx, 16'h0);
        else if (idx == 5'd2) cyc = '{wr: 1'b1, addr: sect, data: CMD_WBUF};
        else if (idx == 5'd3) cyc = '{wr: 1'b1, addr: sect, data: 16'(wc)};
        else if (idx == nseq - 5'd1) cyc = '{wr: 1'b1, addr: sect, data: CMD_WBUF_CONF};
        // locations from start address upward, offsets added across the page end
        else cyc = '{wr: 1'b1, addr: addr + ADDR_W'(idx - 5'd4),
                     data: buf_mem[4'(idx - 5'd4)]};
      end
      default: cyc = '{wr: 1'b0, addr: addr, data: '0};
    endcase
    // status polls are plain reads at the operation address
    if (st inside {FCSL_WAIT, FCSL_POLL, FCSL_RECHK}) begin
      cyc = '{wr: 1'b0, addr: addr, data: '0};
    end
  end

  fcsl_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cstart),
    .cyc(cyc),
    .dq_in(dq_in),
    .pins(pins),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .done(cdone),
    .rdata(crdata)
  );

  // ==========================================================================
  // ahb-lite slave, zero wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  logic go;
  assign go = ap_valid && ap_write && ap_addr == REG_CTRL && !busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr <= '0;
      data <= '0;
    end else if (ap_valid && ap_write && !busy) begin
      if (ap_addr == REG_ADDR) addr <= hwdata[ADDR_W-1:0];
      if (ap_addr == REG_DATA) data <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk) begin
    if (ap_valid && ap_write && !busy && ap_addr == REG_DATA) begin
      buf_mem[wc] <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr[7:0])
        REG_CTRL: hrdata <= {24'h0, 4'(wc), op};
        REG_ADDR: hrdata <= 32'(addr);
        REG_DATA: hrdata <= 32'(data);
        REG_STATUS: hrdata <= {26'h0, ready_busy_n, 1'b0, suspended, bypass, fail, busy};
        // upper byte of autoselect reads left to software as don't care
        REG_RDATA: hrdata <= 32'(rd);
        REG_ID: hrdata <= ID_VALUE;
        REG_COUNT: hrdata <= polls;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // command sequencer and status polling
  assign poll_ok = crdata[POLL_BIT] == data[POLL_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= FCSL_IDLE;
      op <= FCSL_OP_READ;
      wc <= 4'h0;
      busy <= 1'b0;
      fail <= 1'b0;
      bypass <= 1'b0;
      suspended <= 1'b0;
      idx <= 5'd0;
      nseq <= 5'd1;
      polls <= 32'h0;
      rd <= '0;
      cstart <= 1'b0;
    end else begin
      cstart <= 1'b0;
      case (st)
        FCSL_IDLE: begin
          if (go) begin
            op <= fcsl_op_t'(hwdata[3:0]);
            if (hwdata[8]) wc <= 4'h0;
            else if (hwdata[3:0] == FCSL_OP_WBUF) wc <= hwdata[7:4];
            nseq <= seq_len(fcsl_op_t'(hwdata[3:0]), hwdata[7:4]);
            idx <= 5'd0;
            busy <= 1'b1;
            fail <= 1'b0;
            polls <= 32'h0;
            cstart <= 1'b1;
            st <= FCSL_ISSUE;
          end else if (ap_valid && ap_write && !busy && ap_addr == REG_DATA) begin
            wc <= wc + 4'h1;
          end
        end
        FCSL_ISSUE: begin
          if (cdone) begin
            rd <= crdata;
            if (idx == nseq - 5'd1) begin
              case (op)
                FCSL_OP_PROGRAM, FCSL_OP_BYP_PROG, FCSL_OP_WBUF,
                FCSL_OP_SECT_ERASE, FCSL_OP_CHIP_ERASE: begin
                  // status valid after last write strobe, polled at the operation address
                  cstart <= 1'b1;
                  st <= FCSL_WAIT;
                end
                default: begin
                  busy <= 1'b0;
                  st <= FCSL_IDLE;
                end
              endcase
              if (op == FCSL_OP_BYPASS) bypass <= 1'b1;
              if (op == FCSL_OP_BYP_EXIT || op == FCSL_OP_RESET) bypass <= 1'b0;
              if (op == FCSL_OP_SUSPEND) suspended <= 1'b1;
              if (op == FCSL_OP_RESUME) suspended <= 1'b0;
            end else begin
              idx <= idx + 5'd1;
              cstart <= 1'b1;
            end
          end
        end
        FCSL_WAIT: st <= FCSL_POLL;
        FCSL_POLL: begin
          if (cdone) begin
            rd <= crdata;
            polls <= polls + 32'h1;
            if (poll_ok) begin
              // bit seven may settle before the rest: take one more read
              cstart <= 1'b1;
              st <= FCSL_RECHK;
              op <= FCSL_OP_READ;
            end else if (crdata[TIMEOUT_BIT] || polls == 32'(POLL_LIMIT)) begin
              cstart <= 1'b1;
              st <= FCSL_RECHK;
            end else begin
              cstart <= 1'b1;
            end
          end
        end
        FCSL_RECHK: begin
          if (cdone) begin
            rd <= crdata;
            if (op == FCSL_OP_READ) begin
              busy <= 1'b0;
              st <= FCSL_IDLE;
            end else if (poll_ok) begin
              cstart <= 1'b1;
              op <= FCSL_OP_READ;
            end else begin
              // failure: reset returns the device to read
              fail <= 1'b1;
              op <= FCSL_OP_RESET;
              cstart <= 1'b1;
              st <= FCSL_RST;
            end
          end
        end
        FCSL_RST: begin
          if (cdone) begin
            busy <= 1'b0;
            st <= FCSL_IDLE;
          end
        end
        default: st <= FCSL_IDLE;
      endcase
    end
  end

  // first pin cycle of every unlocked sequence
  sequence s_unlock1_out;
    pins.addr == ADDR_UNLOCK1 && dq_out == CMD_UNLOCK1 && dq_oe;
  endsequence
  property p_unlock_first;
    @(posedge hclk) disable iff (!hresetn) cstart && st == FCSL_ISSUE && idx == 5'd0 &&
      op inside {FCSL_OP_PROGRAM, FCSL_OP_AUTOSEL, FCSL_OP_BYPASS, FCSL_OP_ABORT_RST,
                 FCSL_OP_SECT_ERASE, FCSL_OP_CHIP_ERASE, FCSL_OP_WBUF} |=> s_unlock1_out;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("no unlock first");
  property p_poll_reads;
    @(posedge hclk) disable iff (!hresetn) st inside {FCSL_POLL, FCSL_RECHK} |-> pins.we_n;
  endproperty
  a_poll_reads: assert property (p_poll_reads) else $error("write during status poll");
  property p_seq_bound;
    @(posedge hclk) disable iff (!hresetn) st == FCSL_ISSUE |-> nseq <= 5'd21;
  endproperty
  a_seq_bound: assert property (p_seq_bound) else $error("sequence too long");

  property p_fail_resets;
    @(posedge hclk) disable iff (!hresetn) $rose(fail) |-> st == FCSL_RST && op == FCSL_OP_RESET;
  endproperty
  a_fail_resets: assert property (p_fail_resets) else $error("no reset after failure");
endmodule : fcsl_host

// ===== tb/fcsl_flash_model.sv
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module fcsl_flash_model
  import fcsl_pkg::*;
#(
  parameter logic [15:0] DEV_ID1 = 16'h1A2B, // arbitrary value
  parameter logic [15:0] DEV_ID3 = 16'h1A3C, // arbitrary value
  parameter logic [6:0] PROT_SECT = 7'h10,
  parameter int PROG_CYC = 100
) (
  input wire logic hclk,
  input wire fcsl_pins_t pins,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic stall,
  output logic [DATA_W-1:0] dq_in,
  output logic ready_busy_n
);
  logic [15:0] mem [int];
  logic [21:0] a_lat, pa, q_a[$];
  logic [15:0] pd, last_q = 16'h0, q_d[$];
  logic [6:0] es;
  logic busy = 1'h0, ers = 1'h0, chip = 1'h0, asel = 1'h0, byp = 1'h0, timeout_flag = 1'h0;
  logic susp = 1'h0;
  int st = 0, cnt = 0, wc = 0;
  wire wr_act = !pins.ce_n && !pins.we_n;
  wire rd_act = !pins.ce_n && !pins.oe_n;
  // ====================
  // read path
  function automatic logic [15:0] rd_val(input logic [21:0] a);
    if (busy) return {8'h00, ers ? 1'h0 : ~pd[7], 1'h0, timeout_flag, 5'h00};
    if (asel) begin
      case (a[7:0])
        8'h01: return DEV_ID1;
        8'h0F: return DEV_ID3;
        8'h03: return 16'hFF18;
        8'h02: return {15'h7F80, a[21:15] == PROT_SECT};
        default: return 16'hFF00;
      endcase
    end
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  endfunction : rd_val
  // released data bus shows the inverse of the last word
  always @(negedge hclk) dq_in <= rd_act ? rd_val(pins.addr) : ~last_q;
  always @(negedge rd_act) last_q = dq_in;
  assign ready_busy_n = !busy;
  // ====================
  // command decoding
  task automatic go(input logic e, input int n);
    busy = 1'h1;
    ers = e;
    cnt = n;
  endtask : go
  task automatic cmd(input logic [21:0] a, input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (busy) begin
      if (timeout_flag && c == 8'hF0) {busy, timeout_flag} = 2'h0;
      if (c == 8'hB0 && ers && !chip) {busy, susp} = 2'h1;
      return;
    end
    case (st)
      0: begin
        if (c == 8'hF0) asel = 1'h0;
        if (c == 8'h30 && susp) {busy, susp} = 2'h2;
        if (byp) st = (c == 8'hA0) ? 4 : (c == 8'h90) ? 9 : 0;
        if (c == 8'hAA && a[10:0] == 11'h555) st = 1;
      end
      1: st = (c == 8'h55 && a[10:0] == 11'h2AA) ? 2 : 0;
      2: begin
        st = (c == 8'hA0) ? 4 : (c == 8'h80) ? 5 : (c == 8'h25) ? 10 : 0;
        asel = (c == 8'h90) || (asel && c != 8'hF0);
        byp = byp || (c == 8'h20);
      end
      4: begin
        st = 0;
        pa = a;
        pd = d;
        go(1'h0, (a[21:15] == PROT_SECT) ? PROT_PROG_CYC : PROG_CYC);
      end
      5: st = (c == 8'hAA) ? 6 : 0;
      6: st = (c == 8'h55) ? 7 : 0;
      7: begin
        st = 0;
        chip = (c == 8'h10);
        es = a[21:15];
        if (chip || c == 8'h30) go(1'h1, 3 * PROG_CYC);
      end
      9: begin
        st = 0;
        byp = byp && (c != 8'h00);
      end
      10: begin
        st = 11;
        wc = d;
        q_a = {};
        q_d = {};
      end
      11: begin
        q_a.push_back(a);
        q_d.push_back(d);
        if (q_a.size() > wc) st = 12;
      end
      12: begin
        st = 0;
        pa = q_a[$];
        pd = q_d[$];
        if (c == 8'h29 && wc < BUF_MAX_WORDS) go(1'h0, PROG_CYC);
      end
      default: st = 0;
    endcase
  endtask : cmd
  always @(posedge wr_act) a_lat = pins.addr;
  always @(negedge wr_act) cmd(a_lat, dq_out);
  // ====================
  // embedded operation timing
  always @(posedge hclk) begin
    if (busy) begin
      cnt = cnt - 1;
      if (stall && cnt < -150) timeout_flag = 1'h1;
      if (!stall && cnt == 0) begin
        busy = 1'h0;
        foreach (mem[k])
          if (ers && (chip || k[21:15] == es) && k[21:15] != PROT_SECT) mem[k] = 16'hFFFF;
        if (!ers && pa[21:15] != PROT_SECT) mem[int'(pa)] = pd;
        foreach (q_a[i]) mem[int'(q_a[i])] = q_d[i];
        q_a = {};
        q_d = {};
      end
    end
  end
endmodule : fcsl_flash_model

// ===== tb/tb_top.sv
// self-checking bench for the flash command host controller
`timescale 1ns/1ps
module tb_top;
  import fcsl_pkg::*;
  typedef struct {fcsl_op_t op; logic [21:0] a; logic [15:0] d, m, e;} fcsl_row_t;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0, stall = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, dq_oe, ready_busy_n;
  logic [DATA_W-1:0] dq_out, dq_in;
  fcsl_pins_t pins;
  int num_errors = 0, checks_done = 0;
  // autoselect words follow the model's arbitrary defaults
  fcsl_row_t rows [22] = '{
    '{FCSL_OP_PROGRAM, 22'h001234, 16'h5A3C, 16'h0, 16'h0},
    '{FCSL_OP_READ, 22'h001234, 16'h0, 16'hFFFF, 16'h5A3C},
    '{FCSL_OP_AUTOSEL, 22'h000001, 16'h0, 16'hFFFF, 16'h1A2B},
    '{FCSL_OP_AUTOSEL, 22'h00000F, 16'h0, 16'hFFFF, 16'h1A3C},
    '{FCSL_OP_AUTOSEL, 22'h000003, 16'h0, 16'h00FF, 16'h0018},
    '{FCSL_OP_AUTOSEL, 22'h080002, 16'h0, 16'h00FF, 16'h0001},
    '{FCSL_OP_AUTOSEL, 22'h008002, 16'h0, 16'h00FF, 16'h0000},
    '{FCSL_OP_RESET, 22'h0, 16'h0, 16'h0, 16'h0},
    '{FCSL_OP_READ, 22'h001234, 16'h0, 16'hFFFF, 16'h5A3C},
    '{FCSL_OP_SECT_ERASE, 22'h001234, 16'h0080, 16'h0, 16'h0},
    '{FCSL_OP_READ, 22'h001234, 16'h0, 16'hFFFF, 16'hFFFF},
    '{FCSL_OP_BYPASS, 22'h0, 16'h0, 16'h0, 16'h0},
    '{FCSL_OP_BYP_PROG, 22'h002000, 16'h1357, 16'h0, 16'h0},
    '{FCSL_OP_BYP_EXIT, 22'h0, 16'h0, 16'h0, 16'h0},
    '{FCSL_OP_READ, 22'h002000, 16'h0, 16'hFFFF, 16'h1357},
    '{FCSL_OP_PROGRAM, 22'h080010, 16'h00AA, 16'h0, 16'h0},
    '{FCSL_OP_READ, 22'h080010, 16'h0, 16'hFFFF, 16'hFFFF},
    '{FCSL_OP_SUSPEND, 22'h001234, 16'h0080, 16'h0, 16'h0},
    '{FCSL_OP_RESUME, 22'h001234, 16'h0080, 16'h0, 16'h0},
    '{FCSL_OP_ABORT_RST, 22'h0, 16'h0, 16'h0, 16'h0},
    '{FCSL_OP_CHIP_ERASE, 22'h0, 16'h0080, 16'h0, 16'h0},
    '{FCSL_OP_READ, 22'h002000, 16'h0, 16'hFFFF, 16'hFFFF}
  };
  fcsl_host #(.POLL_LIMIT(50)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  fcsl_flash_model flash (.hclk(hclk), .pins(pins), .dq_out(dq_out), .stall(stall),
    .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  // ====================
  // bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : xfer
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(1'h0, REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 3000);
    if (n >= 3000) num_errors++;
  endtask : wait_idle
  task automatic run_op(input fcsl_op_t op, input logic [21:0] a, input logic [15:0] d);
    xfer(1'h1, REG_ADDR, {10'h0, a});
    xfer(1'h1, REG_DATA, {16'h0, d});
    xfer(1'h1, REG_CTRL, {23'h0, 1'h1, 4'h0, op});
    wait_idle();
  endtask : run_op
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // ====================
  // clock, watchdog and tests
  initial forever #2 hclk = ~hclk;
  initial begin
    // well beyond the expected run of some 31 flash operations
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].a, rows[i].d);
      check({31'h0, rd[1]}, 32'h0);
      xfer(1'h0, REG_RDATA, 32'h0);
      check(rd & {16'h0, rows[i].m}, {16'h0, rows[i].e});
      $display("row %0d done", i);
    end
    run_op(FCSL_OP_READ, 22'h003000, 16'h0);
    for (int i = 0; i < 4; i++) xfer(1'h1, REG_DATA, 32'hA000 + i);
    xfer(1'h1, REG_CTRL, {24'h0, 4'h3, FCSL_OP_WBUF});
    wait_idle();
    check({31'h0, rd[1]}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      run_op(FCSL_OP_READ, 22'h003000 + 22'(i), 16'h0);
      xfer(1'h0, REG_RDATA, 32'h0);
      check(rd & 32'hFFFF, 32'hA000 + i);
    end
    $display("buffer test done");
    run_op(FCSL_OP_BYP_PROG, 22'h002002, 16'h2468);
    run_op(FCSL_OP_READ, 22'h002002, 16'h0);
    xfer(1'h0, REG_RDATA, 32'h0);
    check(rd & 32'hFFFF, 32'hFFFF);
    $display("bypass refusal test done");
    stall <= 1'h1;
    run_op(FCSL_OP_PROGRAM, 22'h004000, 16'h0011);
    check({31'h0, rd[1]}, 32'h1);
    check({31'h0, rd[5]}, 32'h1);
    stall <= 1'h0;
    $display("timeout test done");
    hresetn <= 1'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(1'h1, 8'h1C, 32'hFFFFFFFF);
    xfer(1'h1, REG_ID, 32'h0);
    xfer(1'h0, REG_ID, 32'h0);
    check(rd, ID_VALUE);
    xfer(1'h0, REG_STATUS, 32'h0);
    check(rd & 32'h23, 32'h20);
    $display("reset test done");
    complete_run();
  end
endmodule : tb_top
